// *** pvw_arb.sv ***
// Purpose: picks the winning vector among pending ones
// Assumes: purely combinational, fed from same-clock logic
// Notes:   level first, lowest vector index on a tie
`timescale 1ns/10ps
`default_nettype none

module pvw_arb
  import pvw_pkg::*;
(
  input  wire logic [NVEC-1:0]       vec_pend,
  input  wire logic [LVL_W*NVEC-1:0] vec_level,
  input  wire logic [NLVL-1:0]       svc_mask,
  output logic                       win_ok,
  output logic [IDX_W-1:0]           win_idx,
  output logic [LVL_W-1:0]           win_lvl
);

  // ----------------------------------------------------------------
  // search
  // ----------------------------------------------------------------
  logic             found;
  logic [LVL_W-1:0] best_lvl;
  logic [IDX_W-1:0] best_idx;

  // ascending scan with a strict compare, so a tie keeps the lower address
  always_comb begin
    found    = 1'b0;
    best_lvl = '0;
    best_idx = '0;
    for (int v = 0; v < NVEC; v++) begin
      if (vec_pend[v] && (!found || lvl_of(vec_level, v) > best_lvl)) begin
        found    = 1'b1;
        best_lvl = lvl_of(vec_level, v);
        best_idx = IDX_W'(v);
      end
    end
    win_idx = best_idx;
    win_lvl = best_lvl;
    // only the top pending level is checked: if it is blocked all are
    win_ok  = found && lvl_open(svc_mask, best_lvl);
  end

endmodule

`default_nettype wire

// *** pvw_cpu_model.sv ***
// Purpose: core-side model that takes and returns from interrupts
// Assumes: drives on the falling edge, as the bench does
// Notes:   ack_dly 0 answers at once; larger values answer slowly
`timescale 1ns/10ps
`default_nettype none

module pvw_cpu_model (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       irq_req_q,
  input  wire logic       ack_on,
  input  wire logic [3:0] ack_dly,
  input  wire logic       reti_go,
  output var  logic       irq_ack,
  output var  logic       irq_reti
);
  logic [3:0] wait_q;

  // ----------------------------------------------------------------
  // take a request only while it is presented
  // ----------------------------------------------------------------
  // one idle cycle between acks, so a dropped request is never taken twice
  always @(negedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_ack  <= 1'b0;
      irq_reti <= 1'b0;
      wait_q   <= 4'h0;
    end else begin
      irq_reti <= reti_go;
      if (ack_on && irq_req_q && !irq_ack && wait_q == ack_dly) begin
        irq_ack <= 1'b1;
        wait_q  <= 4'h0;
      end else begin
        irq_ack <= 1'b0;
        wait_q  <= (ack_on && irq_req_q && !irq_ack) ? wait_q + 4'h1 : 4'h0;
      end
    end
  end
endmodule

`default_nettype wire

// *** pvw_irq_wakeup.sv ***
// Purpose: vectored interrupt controller with three nesting levels and
//          the standby (halt, hold, sub-clock stop) wake-up control
// Assumes: source flags and enables come from same-clock peripherals;
//          external interrupt pins are asynchronous
// Notes:   source flags stay in the peripherals and are cleared there
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// - three levels, nested service tracked per level
// - no grant at or below serviced level
// - highest pending level wins
// - equal level: smallest vector address wins
// - 61 sources folded onto 14 vectors
// - 08018H: pin 2, timer 1, async 2
// - 0801CH: pin 3, timer 2, both i2c
// - 0803CH: ports 0 and 5, clock, crc
// - 0802CH: pwm unit and master i2c 1
// - 08030H: converter, timer 5, sync serial 4
// - halt: core stops, peripherals and oscillators run
// - hold: everything stops, all oscillators off
// - hold ends on pins, ports, serial units
// - sub-clock stop: fast oscillators off, crystal kept
// - sub-clock stop adds timer, receiver, clock wake
module pvw_irq_wakeup
  import pvw_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  rstn,
  input  wire logic                  ce,
  input  wire logic [NSRC-1:0]       src_flag,
  input  wire logic [NSRC-1:0]       src_en,
  input  wire logic [LVL_W*NVEC-1:0] vec_level,
  input  wire logic                  irq_ack,
  input  wire logic                  irq_reti,
  input  wire logic [NPIN-1:0]       ext_irq_pin,
  input  wire logic [NPIN-1:0]       pin_wake_level,
  input  wire logic                  halt_req,
  input  wire logic                  hold_req,
  input  wire logic                  sstop_req,
  input  wire logic                  main_osc_on,
  input  wire logic                  rc_osc_on,
  input  wire logic                  low_osc_on,
  output var  logic                  irq_req_q,
  output var  logic [ADDR_W-1:0]     irq_addr_q,
  output var  logic [LVL_W-1:0]      irq_lvl_q,
  output var  logic [NLVL-1:0]       in_svc_q,
  output var  logic [NVEC-1:0]       vec_pend_q,
  output var  logic                  cpu_run_q,
  output var  logic                  periph_run_q,
  output var  logic                  lowclk_run_q,
  output var  logic                  main_osc_en_q,
  output var  logic                  rc_osc_en_q,
  output var  logic                  low_osc_en_q
);

  // ----------------------------------------------------------------
  // pin synchroniser
  // ----------------------------------------------------------------
  logic [NPIN-1:0] pin_s1_q;
  logic [NPIN-1:0] pin_s2_q;

  // the pins are asynchronous; only the second stage is looked at
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
    end else if (ce) begin
      pin_s1_q <= ext_irq_pin;
      pin_s2_q <= pin_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // pending and arbitration
  // ----------------------------------------------------------------
  logic [NSRC-1:0]   src_act;
  logic [NVEC-1:0]   vec_pend_d;
  logic [NLVL-1:0]   in_svc_d;
  logic              irq_req_d;
  logic [ADDR_W-1:0] irq_addr_d;
  logic [LVL_W-1:0]  irq_lvl_d;
  logic              win_ok;
  logic [IDX_W-1:0]  win_idx;
  logic [LVL_W-1:0]  win_lvl;
  pvw_mode_t         mode_q;
  pvw_mode_t         mode_d;

  assign src_act = src_flag & src_en;

  // per-vector OR of the enabled flags, grouped by the source layout
  always_comb begin
    for (int v = 0; v < NVEC; v++) begin
      vec_pend_d[v] = |(src_act & vec_mask(v));
    end
  end

  // return drops the deepest level first; an ack in the same cycle
  // still sets its own level, so the new entry is never lost
  always_comb begin
    in_svc_d = in_svc_q;
    if (irq_reti) begin
      if (in_svc_d[2]) begin
        in_svc_d[2] = 1'b0;
      end else if (in_svc_d[1]) begin
        in_svc_d[1] = 1'b0;
      end else begin
        in_svc_d[0] = 1'b0;
      end
    end
    if (irq_ack && irq_req_q) begin
      in_svc_d[irq_lvl_q] = 1'b1;
    end
  end

  // arbitration looks at next-cycle service state, so an acked
  // request is withdrawn at the very next edge
  pvw_arb u_arb (
    .vec_pend  (vec_pend_d),
    .vec_level (vec_level),
    .svc_mask  (in_svc_d),
    .win_ok    (win_ok),
    .win_idx   (win_idx),
    .win_lvl   (win_lvl)
  );

  // requests reach the core only in full run, i.e. after wake settle
  always_comb begin
    irq_req_d  = win_ok && (mode_d == ST_RUN);
    irq_addr_d = VEC_ADDR[win_idx];
    irq_lvl_d  = win_lvl;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      vec_pend_q <= '0;
      in_svc_q   <= '0;
      irq_req_q  <= 1'b0;
      irq_addr_q <= '0;
      irq_lvl_q  <= '0;
    end else if (ce) begin
      vec_pend_q <= vec_pend_d;
      in_svc_q   <= in_svc_d;
      irq_req_q  <= irq_req_d;
      irq_addr_q <= irq_addr_d;
      irq_lvl_q  <= irq_lvl_d;
    end
  end

  // ----------------------------------------------------------------
  // standby control
  // ----------------------------------------------------------------
  logic             pin_hit;
  logic             hold_wake;
  logic             sstop_wake;
  logic [CNT_W-1:0] wake_cnt_q;
  logic [CNT_W-1:0] wake_cnt_d;
  logic             cpu_run_d;
  logic             periph_run_d;
  logic             lowclk_run_d;
  logic             main_osc_en_d;
  logic             rc_osc_en_d;
  logic             low_osc_en_d;

  // wake causes: an unmasked pin at its programmed level or an enabled wake-capable source
  always_comb begin
    pin_hit    = |(~(pin_s2_q ^ pin_wake_level) & HOLD_PIN_MASK);
    hold_wake  = pin_hit || |(src_act & HOLD_WAKE_SRC);
    sstop_wake = pin_hit || |(src_act & SSTOP_WAKE_SRC);
  end

  // mode sequence; hold beats sub-clock stop beats halt on a tie
  always_comb begin
    mode_d     = mode_q;
    wake_cnt_d = wake_cnt_q;
    case (mode_q)
      ST_RUN: begin
        if (hold_req) begin
          mode_d = ST_HOLD;
        end else if (sstop_req) begin
          mode_d = ST_SSTOP;
        end else if (halt_req) begin
          mode_d = ST_HALT;
        end
      end
      ST_HALT: begin
        if (|vec_pend_d) begin
          mode_d = ST_RUN;
        end
      end
      ST_HOLD: begin
        if (hold_wake) begin
          mode_d     = ST_WAKE;
          wake_cnt_d = '0;
        end
      end
      ST_SSTOP: begin
        if (sstop_wake) begin
          mode_d     = ST_WAKE;
          wake_cnt_d = '0;
        end
      end
      ST_WAKE: begin
        // oscillators restart here; the core waits for them
        if (wake_cnt_q == CNT_W'(OSC_SETTLE_CYC - 1)) begin
          mode_d = ST_RUN;
        end else begin
          wake_cnt_d = wake_cnt_q + 1'b1;
        end
      end
      default: begin
        mode_d = ST_RUN;
      end
    endcase
  end

  // clock and run enables follow the next mode
  always_comb begin
    cpu_run_d    = (mode_d == ST_RUN);
    periph_run_d = (mode_d == ST_RUN) || (mode_d == ST_HALT);
    lowclk_run_d = periph_run_d || (mode_d == ST_SSTOP);
    main_osc_en_d = main_osc_on;
    rc_osc_en_d   = rc_osc_on;
    low_osc_en_d  = low_osc_on;
    if (mode_d == ST_HOLD) begin
      main_osc_en_d = 1'b0;
      rc_osc_en_d   = 1'b0;
      low_osc_en_d  = 1'b0;
    end else if (mode_d == ST_SSTOP) begin
      main_osc_en_d = 1'b0;
      rc_osc_en_d   = 1'b0;
      low_osc_en_d  = low_osc_en_q; // frozen at entry
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mode_q        <= ST_RUN;
      wake_cnt_q    <= '0;
      cpu_run_q     <= 1'b1;
      periph_run_q  <= 1'b1;
      lowclk_run_q  <= 1'b1;
      main_osc_en_q <= 1'b0;
      rc_osc_en_q   <= 1'b0;
      low_osc_en_q  <= 1'b0;
    end else if (ce) begin
      mode_q        <= mode_d;
      wake_cnt_q    <= wake_cnt_d;
      cpu_run_q     <= cpu_run_d;
      periph_run_q  <= periph_run_d;
      lowclk_run_q  <= lowclk_run_d;
      main_osc_en_q <= main_osc_en_d;
      rc_osc_en_q   <= rc_osc_en_d;
      low_osc_en_q  <= low_osc_en_d;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // true when some pending vector beats vector idx
  function automatic logic beaten(input logic [NVEC-1:0] p,
                                  input logic [LVL_W*NVEC-1:0] l,
                                  input logic [IDX_W-1:0] idx,
                                  input logic tie);
    logic b;
    b = 1'b0;
    for (int v = 0; v < NVEC; v++) begin
      if (p[v] && lvl_of(l, v) > lvl_of(l, int'(idx))) begin
        b = 1'b1;
      end
      if (tie && p[v] && v < int'(idx) && lvl_of(l, v) == lvl_of(l, int'(idx))) begin
        b = 1'b1;
      end
    end
    return b;
  endfunction

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  sequence s_ack_taken;
    ce && irq_ack && irq_req_q && !irq_reti;
  endsequence

  sequence s_hold_wake;
    ce && mode_q == ST_HOLD && hold_wake;
  endsequence

  sequence s_sstop_wake;
    ce && mode_q == ST_SSTOP && sstop_wake;
  endsequence

  a_ack_nests: assert property (
    s_ack_taken |=> in_svc_q[$past(irq_lvl_q)] &&
      (!irq_req_q || irq_lvl_q > $past(irq_lvl_q)))
    else $error("acked level not marked in service");

  a_req_level_open: assert property (
    irq_req_q |-> lvl_open(in_svc_q, irq_lvl_q) && cpu_run_q)
    else $error("request at or below the serviced level");

  a_top_level: assert property (
    win_ok |-> !beaten(vec_pend_d, vec_level, win_idx, 1'b0))
    else $error("a higher level pending vector lost");

  a_low_addr: assert property (
    win_ok |-> !beaten(vec_pend_d, vec_level, win_idx, 1'b1))
    else $error("a smaller address at equal level lost");

  a_pend_or: assert property (
    ce && src_act == '0 |=> vec_pend_q == '0 && !irq_req_q)
    else $error("vector pending with no enabled flag");

  a_halt_runs: assert property (
    ce && mode_q == ST_HALT |=> periph_run_q && !cpu_run_q ||
      (cpu_run_q && $past(|vec_pend_d)))
    else $error("halt stopped peripherals or left without cause");

  a_hold_off: assert property (
    mode_q == ST_HOLD |-> !main_osc_en_q && !rc_osc_en_q && !low_osc_en_q &&
      !periph_run_q && !cpu_run_q)
    else $error("hold left an oscillator or block running");

  a_hold_wake: assert property (
    s_hold_wake |=> mode_q == ST_WAKE ##0 !irq_req_q)
    else $error("hold not ended by a wake source");

  a_sstop_keep: assert property (
    ce && mode_q == ST_SSTOP && !sstop_wake |=> $stable(low_osc_en_q) &&
      lowclk_run_q && !main_osc_en_q && !rc_osc_en_q)
    else $error("sub-clock stop changed the crystal or fast clocks");

  a_sstop_wake: assert property (
    s_sstop_wake |=> mode_q == ST_WAKE)
    else $error("sub-clock stop not ended by a wake source");

  a_wake_quiet: assert property (
    mode_q == ST_WAKE |-> !irq_req_q && !cpu_run_q &&
      wake_cnt_q < CNT_W'(OSC_SETTLE_CYC))
    else $error("request raised before clocks settled");

endmodule

`default_nettype wire

// *** pvw_pkg.sv ***
// Purpose: shared constants, source layout and helpers of the vectored
//          interrupt controller with standby wake-up
// Assumes: one system clock at 250 MHz
// Notes:   sources are a flat vector, grouped by vector in address order
`default_nettype none

package pvw_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int NSRC   = 61;
  localparam int NVEC   = 14;
  localparam int NLVL   = 3;
  localparam int LVL_W  = 2;
  localparam int IDX_W  = 4;
  localparam int ADDR_W = 20;
  localparam int NPIN   = 8;

  // level codes: 0 low, 1 high, 2 highest; code 3 is read as highest
  localparam logic [LVL_W-1:0] LVL_MAX = 2'h2;

  typedef enum logic [2:0] {
    ST_RUN,
    ST_HALT,
    ST_HOLD,
    ST_SSTOP,
    ST_WAKE
  } pvw_mode_t;

  // ----------------------------------------------------------------
  // vector table and source layout
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] VEC_ADDR [NVEC] = '{
    20'h08000, 20'h08004, 20'h08008, 20'h0800C, 20'h08014,
    20'h08018, 20'h0801C, 20'h08020, 20'h08024, 20'h0802C,
    20'h08030, 20'h08034, 20'h08038, 20'h0803C};
  localparam int VEC_FIRST [NVEC] = '{0, 1, 3, 5, 6, 7, 14, 21, 28, 32, 34, 38, 44, 48};
  localparam int VEC_LAST  [NVEC] = '{0, 2, 4, 5, 6, 13, 20, 27, 31, 33, 37, 43, 47, 60};

  // wake-capable source groups
  localparam int SRC_BTM_LO  = 1;
  localparam int SRC_BTM_HI  = 2;
  localparam int SRC_UA2_LO  = 10;
  localparam int SRC_UA2_HI  = 13;
  localparam int SRC_IR_LO   = 24;
  localparam int SRC_IR_HI   = 27;
  localparam int SRC_SS1_LO  = 30;
  localparam int SRC_SS1_HI  = 31;
  localparam int SRC_SS4_LO  = 36;
  localparam int SRC_SS4_HI  = 37;
  localparam int SRC_UA3_LO  = 40;
  localparam int SRC_UA3_HI  = 43;
  localparam int SRC_SS0_LO  = 45;
  localparam int SRC_SS0_HI  = 47;
  localparam int SRC_PORT_LO = 48;
  localparam int SRC_PORT_HI = 58;
  localparam int SRC_RTC     = 59;

  // external pins that can end hold: all but pin 3
  localparam logic [NPIN-1:0] HOLD_PIN_MASK = 8'hF7;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ        = 250;
  localparam int OSC_SETTLE_NS  = 1000;
  localparam int OSC_SETTLE_CYC = (OSC_SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W          = $clog2(OSC_SETTLE_CYC + 1);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [NSRC-1:0] src_range(input int lo, input int hi);
    logic [NSRC-1:0] m;
    m = '0;
    for (int i = 0; i < NSRC; i++) begin
      if (i >= lo && i <= hi) begin
        m[i] = 1'b1;
      end
    end
    return m;
  endfunction

  function automatic logic [NSRC-1:0] vec_mask(input int v);
    return src_range(VEC_FIRST[v], VEC_LAST[v]);
  endfunction

  function automatic logic [LVL_W-1:0] lvl_of(input logic [LVL_W*NVEC-1:0] l,
                                               input int v);
    logic [LVL_W-1:0] x;
    x = l[LVL_W*v +: LVL_W];
    return (x > LVL_MAX) ? LVL_MAX : x;
  endfunction

  // a level is open when nothing at or above it is in service
  function automatic logic lvl_open(input logic [NLVL-1:0] svc,
                                    input logic [LVL_W-1:0] lvl);
    return (svc >> lvl) == '0;
  endfunction

  localparam logic [NSRC-1:0] HOLD_WAKE_SRC =
    src_range(SRC_PORT_LO, SRC_PORT_HI) | src_range(SRC_SS0_LO, SRC_SS0_HI) |
    src_range(SRC_SS1_LO, SRC_SS1_HI) | src_range(SRC_SS4_LO, SRC_SS4_HI) |
    src_range(SRC_UA2_LO, SRC_UA2_HI) | src_range(SRC_UA3_LO, SRC_UA3_HI);
  localparam logic [NSRC-1:0] SSTOP_WAKE_SRC = HOLD_WAKE_SRC |
    src_range(SRC_BTM_LO, SRC_BTM_HI) | src_range(SRC_IR_LO, SRC_IR_HI) |
    src_range(SRC_RTC, SRC_RTC);

endpackage

`default_nettype wire

// *** tb_top.sv ***
// Purpose: self-checking bench for the vectored controller and wake-up
// Assumes: inputs change on the falling edge by non-blocking assignment
// Notes:   the settle count is the package value, no shortening
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  import pvw_pkg::*;

  logic                  clk            = 1'b0;
  logic                  rstn           = 1'b0;
  logic                  ce             = 1'b1;
  logic [NSRC-1:0]       src_flag       = '0;
  logic [NSRC-1:0]       src_en         = '1;
  logic [LVL_W*NVEC-1:0] vec_level      = '0;
  logic [NPIN-1:0]       ext_irq_pin    = '0;
  logic [NPIN-1:0]       pin_wake_level = '1;
  logic                  halt_req       = 1'b0;
  logic                  hold_req       = 1'b0;
  logic                  sstop_req      = 1'b0;
  logic                  main_osc_on    = 1'b1;
  logic                  rc_osc_on      = 1'b1;
  logic                  low_osc_on     = 1'b1;
  logic                  ack_on         = 1'b0;
  logic [3:0]            ack_dly        = 4'h0;
  logic                  reti_go        = 1'b0;
  logic                  irq_ack;
  logic                  irq_reti;
  logic                  irq_req_q;
  logic [ADDR_W-1:0]     irq_addr_q;
  logic [LVL_W-1:0]      irq_lvl_q;
  logic [NLVL-1:0]       in_svc_q;
  logic [NVEC-1:0]       vec_pend_q;
  logic                  cpu_run_q;
  logic                  periph_run_q;
  logic                  lowclk_run_q;
  logic                  main_osc_en_q;
  logic                  rc_osc_en_q;
  logic                  low_osc_en_q;
  int                    miscompares    = 0;
  int                    n_compared     = 0;
  int                    cyc            = 0;
  logic [NSRC-1:0]       one;

  localparam int           SH_SRC  [10] = '{7, 13, 14, 20, 32, 33, 34, 37, 48, 60};
  localparam logic [19:0]  SH_ADDR [10] = '{20'h08018, 20'h08018, 20'h0801C, 20'h0801C,
    20'h0802C, 20'h0802C, 20'h08030, 20'h08030, 20'h0803C, 20'h0803C};

  always #2 clk = ~clk;

  pvw_irq_wakeup u_dut (
    .clk(clk), .rstn(rstn), .ce(ce), .src_flag(src_flag), .src_en(src_en),
    .vec_level(vec_level), .irq_ack(irq_ack), .irq_reti(irq_reti),
    .ext_irq_pin(ext_irq_pin), .pin_wake_level(pin_wake_level),
    .halt_req(halt_req), .hold_req(hold_req), .sstop_req(sstop_req),
    .main_osc_on(main_osc_on), .rc_osc_on(rc_osc_on), .low_osc_on(low_osc_on),
    .irq_req_q(irq_req_q), .irq_addr_q(irq_addr_q), .irq_lvl_q(irq_lvl_q),
    .in_svc_q(in_svc_q), .vec_pend_q(vec_pend_q), .cpu_run_q(cpu_run_q),
    .periph_run_q(periph_run_q), .lowclk_run_q(lowclk_run_q),
    .main_osc_en_q(main_osc_en_q), .rc_osc_en_q(rc_osc_en_q),
    .low_osc_en_q(low_osc_en_q));

  pvw_cpu_model u_cpu (
    .clk(clk), .rstn(rstn), .irq_req_q(irq_req_q), .ack_on(ack_on),
    .ack_dly(ack_dly), .reti_go(reti_go), .irq_ack(irq_ack), .irq_reti(irq_reti));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  task chk(input string nm, input logic [19:0] e, input logic [19:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task set_lvl(input int v, input logic [1:0] l);
    vec_level[2*v +: 2] <= l;
  endtask

  task complete_run;
    $display("checks %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // hang guard: the whole sequence needs well under 3000 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      complete_run();
    end
  end

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  // every source alone, then named shared groups, then a masked source
  task t_map;
    for (int v = 0; v < NVEC; v++) begin
      for (int s = VEC_FIRST[v]; s <= VEC_LAST[v]; s++) begin
        one = '0;
        one[s] = 1'b1;
        src_flag <= one;
        tick(1);
        chk("addr", VEC_ADDR[v], irq_addr_q);
        chk("pend", 20'(14'h1 << v), 20'(vec_pend_q));
        src_flag <= '0;
        tick(1);
      end
    end
    for (int k = 0; k < 10; k++) begin
      one = '0;
      one[SH_SRC[k]] = 1'b1;
      src_flag <= one;
      tick(1);
      chk("shared", SH_ADDR[k], irq_addr_q);
      src_flag <= '0;
      tick(1);
    end
    src_en[7] <= 1'b0;
    src_flag[7] <= 1'b1;
    tick(2);
    chk("masked", 20'h0, 20'(vec_pend_q));
    src_flag <= '0;
    src_en <= '1;
    tick(1);
    // clock enable low must freeze the pending path
    ce <= 1'b0;
    src_flag[5] <= 1'b1;
    tick(2);
    chk("frozen", 20'h0, 20'(irq_req_q));
    ce <= 1'b1;
    tick(1);
    chk("thawed", 20'h0800C, irq_addr_q);
    src_flag <= '0;
    tick(1);
  endtask

  // level beats address, address breaks a tie, code 3 counts as highest
  task t_prio;
    set_lvl(9, 2'h1);
    set_lvl(11, 2'h1);
    src_flag[3] <= 1'b1;
    src_flag[32] <= 1'b1;
    src_flag[38] <= 1'b1;
    tick(1);
    chk("tie", 20'h0802C, irq_addr_q);
    chk("tie lvl", 20'h1, 20'(irq_lvl_q));
    set_lvl(11, 2'h2);
    tick(1);
    chk("top", 20'h08034, irq_addr_q);
    set_lvl(2, 2'h3);
    tick(1);
    chk("top tie", 20'h08008, irq_addr_q);
    src_flag <= '0;
    vec_level <= '0;
    tick(1);
  endtask

  // nesting: same level refused, higher taken, returns unwind in order
  task t_nest;
    ack_on <= 1'b1;
    ack_dly <= 4'h2;
    set_lvl(3, 2'h1);
    src_flag[7] <= 1'b1;
    tick(6);
    chk("svc low", 20'h1, 20'(in_svc_q));
    src_flag[14] <= 1'b1;
    tick(3);
    chk("same lvl req", 20'h0, 20'(irq_req_q));
    chk("same lvl svc", 20'h1, 20'(in_svc_q));
    src_flag[5] <= 1'b1;
    tick(6);
    chk("svc nested", 20'h3, 20'(in_svc_q));
    src_flag[5] <= 1'b0;
    ack_on <= 1'b0;
    reti_go <= 1'b1;
    tick(1);
    reti_go <= 1'b0;
    tick(2);
    chk("reti top", 20'h1, 20'(in_svc_q));
    chk("still refused", 20'h0, 20'(irq_req_q));
    reti_go <= 1'b1;
    tick(1);
    reti_go <= 1'b0;
    tick(2);
    chk("reti all", 20'h0, 20'(in_svc_q));
    chk("reopen", 20'h08018, irq_addr_q);
    src_flag <= '0;
    vec_level <= '0;
    tick(2);
  endtask

  // halt keeps peripherals and oscillators, any interrupt ends it
  task t_halt;
    int i;
    halt_req <= 1'b1;
    tick(1);
    halt_req <= 1'b0;
    chk("halt cpu", 20'h0, 20'(cpu_run_q));
    chk("halt per", 20'h1, 20'(periph_run_q));
    chk("halt osc", 20'h1, 20'(main_osc_en_q & rc_osc_en_q & low_osc_en_q));
    src_flag[34] <= 1'b1;
    for (i = 0; i < 4 && cpu_run_q !== 1'b1; i++) tick(1);
    chk("halt end", 20'h1, 20'(cpu_run_q));
    chk("halt irq", 20'h08030, irq_addr_q);
    src_flag <= '0;
    tick(1);
  endtask

  // hold stops all, ignores other sources, wakes on port 0 after settle
  task t_hold;
    hold_req <= 1'b1;
    tick(1);
    hold_req <= 1'b0;
    chk("hold run", 20'h0, 20'({cpu_run_q, periph_run_q, lowclk_run_q}));
    chk("hold osc", 20'h0, 20'({main_osc_en_q, rc_osc_en_q, low_osc_en_q}));
    src_flag[22] <= 1'b1;
    ext_irq_pin[3] <= 1'b1;
    tick(6);
    chk("hold stays", 20'h0, 20'(main_osc_en_q));
    src_flag[22] <= 1'b0;
    src_flag[48] <= 1'b1;
    tick(1);
    chk("wake osc", 20'h7, 20'({main_osc_en_q, rc_osc_en_q, low_osc_en_q}));
    tick(OSC_SETTLE_CYC - 1);
    chk("settling", 20'h0, 20'(cpu_run_q));
    tick(1);
    chk("resumed", 20'h1, 20'(cpu_run_q));
    chk("woken irq", 20'h0803C, irq_addr_q);
    src_flag <= '0;
    tick(1);
  endtask

  // sub-clock stop keeps the crystal as entered; the clock source wakes it
  task t_sstop;
    int i;
    sstop_req <= 1'b1;
    tick(1);
    sstop_req <= 1'b0;
    low_osc_on <= 1'b0;
    chk("x fast osc", 20'h0, 20'({main_osc_en_q, rc_osc_en_q}));
    chk("x low clk", 20'h1, 20'(lowclk_run_q));
    chk("x per", 20'h0, 20'(periph_run_q));
    tick(3);
    chk("x crystal", 20'h1, 20'(low_osc_en_q));
    low_osc_on <= 1'b1;
    src_flag[59] <= 1'b1;
    tick(2);
    chk("x wake", 20'h1, 20'(main_osc_en_q));
    for (i = 0; i < 300 && cpu_run_q !== 1'b1; i++) tick(1);
    chk("x resumed", 20'h1, 20'(cpu_run_q));
    src_flag <= '0;
    tick(1);
  endtask

  // pin 3 never ends hold, pin 0 at its level does after the synchroniser
  task t_pin;
    int i;
    ext_irq_pin <= 8'h08;
    hold_req <= 1'b1;
    tick(1);
    hold_req <= 1'b0;
    tick(6);
    chk("pin3 ignored", 20'h0, 20'(main_osc_en_q));
    ext_irq_pin <= 8'h01;
    for (i = 0; i < 6 && main_osc_en_q !== 1'b1; i++) tick(1);
    chk("pin0 wake", 20'h1, 20'(main_osc_en_q));
    for (i = 0; i < 300 && cpu_run_q !== 1'b1; i++) tick(1);
    chk("pin resumed", 20'h1, 20'(cpu_run_q));
    ext_irq_pin <= 8'h00;
    tick(1);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    tick(16);
    chk("reset req", 20'h0, 20'(irq_req_q));
    rstn <= 1'b1;
    tick(2);
    t_map();
    t_prio();
    t_nest();
    t_halt();
    t_hold();
    t_sstop();
    t_pin();
    complete_run();
  end
endmodule

`default_nettype wire
